// *** design/rs_outer_decoder_rx.sv ***
/*
  Receive outer decoder path: serial in, page lock on unique word,
  de-interleave, single-symbol correction, check byte strip FIFO,
  serial out with self-synchronising descrambler.
  Assumes rx_clk_in, rx_data_in, rate_sel and bypass_in are asynchronous
  pins; rx data is stable around the rising edge of rx_clk_in.
*/
`default_nettype none
module rs_outer_decoder_rx
  import rs_rx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_clk_in,
  input wire logic rx_data_in,
  input wire logic [1:0] rate_sel,
  input wire logic bypass_in,
  output logic out_data,
  output logic out_clk,
  output logic out_valid,
  output logic locked,
  output logic corr_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  function automatic logic [7:0] mulx(input logic [7:0] a);
    mulx = {a[6:0], 1'b0} ^ (a[7] ? `RS_GF_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] gf_mul(input logic [7:0] a,
                                        input logic [7:0] b);
    logic [7:0] acc;
    logic [7:0] p;
    acc = 8'h00;
    p = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) acc = acc ^ p;
      p = mulx(p);
    end
    gf_mul = acc;
  endfunction

  // Pin synchronisers
  logic rclk_s1, rclk_s2, rclk_d, rdat_s1, rdat_s2, byp_s1, byp_s2;
  logic [1:0] rate_s1, rate_s2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {rclk_s1, rclk_s2, rclk_d, rdat_s1, rdat_s2} <= 5'h00;
      {byp_s1, byp_s2, rate_s1, rate_s2} <= 6'h00;
    end else begin
      rclk_s1 <= rx_clk_in;
      rclk_s2 <= rclk_s1;
      rclk_d <= rclk_s2;
      rdat_s1 <= rx_data_in;
      rdat_s2 <= rdat_s1;
      byp_s1 <= bypass_in;
      byp_s2 <= byp_s1;
      rate_s1 <= rate_sel;
      rate_s2 <= rate_s1;
    end
  end
  logic rise;
  assign rise = rclk_s2 & ~rclk_d;

  logic [7:0] k_sel, n_sel;
  always_comb begin
    case (rate_s2)
      2'h0: begin k_sel = `RS_K0; n_sel = `RS_N0; end
      2'h1: begin k_sel = `RS_K1; n_sel = `RS_N1; end
      2'h2: begin k_sel = `RS_K2; n_sel = `RS_N2; end
      default: begin k_sel = `RS_K3; n_sel = `RS_N3; end
    endcase
  end

  // Receive framing and page store writes
  lock_state_t lk_reg;
  logic [15:0] sh_reg, sh_next;
  logic [3:0] bitc_reg;
  logic [9:0] pcnt_reg, page_len;
  logic bank_reg, page_go, wr_en;
  logic [7:0] k_lat_reg, n_lat_reg;
  logic [`RS_RAM_AW-1:0] wr_addr;
  assign sh_next = {sh_reg[14:0], rdat_s2};
  assign page_len = 10'({2'h0, k_lat_reg} << 2);
  assign wr_en = (lk_reg == L_DATA) && rise && (bitc_reg == 4'h7);
  assign wr_addr = {bank_reg, pcnt_reg[1:0], pcnt_reg[9:2]};
  assign page_go = (lk_reg == L_UW) && rise && (bitc_reg == 4'hF) &&
                   (sh_next == `RS_UW);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lk_reg <= L_HUNT;
      sh_reg <= 16'h0000;
      bitc_reg <= 4'h0;
      pcnt_reg <= 10'h000;
      bank_reg <= 1'b0;
      k_lat_reg <= `RS_K0;
      n_lat_reg <= `RS_N0;
    end else if (rise) begin
      sh_reg <= sh_next;
      bitc_reg <= bitc_reg + 4'h1;
      case (lk_reg)
        L_HUNT: begin
          if (sh_next == `RS_UW) begin
            lk_reg <= L_DATA;
            bitc_reg <= 4'h0;
            pcnt_reg <= 10'h000;
            k_lat_reg <= k_sel;
            n_lat_reg <= n_sel;
          end
        end
        L_DATA: begin
          if (bitc_reg == 4'h7) begin
            bitc_reg <= 4'h0;
            pcnt_reg <= pcnt_reg + 10'h001;
            if (pcnt_reg == page_len - 10'h001) lk_reg <= L_UW;
          end
        end
        L_UW: begin
          if (bitc_reg == 4'hF) begin
            bitc_reg <= 4'h0;
            pcnt_reg <= 10'h000;
            // Missing marker drops lock rather than guessing
            if (page_go) begin
              lk_reg <= L_DATA;
              bank_reg <= ~bank_reg;
              k_lat_reg <= k_sel;
              n_lat_reg <= n_sel;
            end else begin
              lk_reg <= L_HUNT;
            end
          end
        end
        default: lk_reg <= L_HUNT;
      endcase
    end
  end

  uw_lock_a: assert property ((lk_reg == L_HUNT) && rise &&
    (sh_next == `RS_UW) |=> (lk_reg == L_DATA) && (pcnt_reg == 10'h000))
    else $error("no lock after unique word");
  interleave_a: assert property (wr_en |->
    (wr_addr[9:8] == pcnt_reg[1:0]) ##1 (bitc_reg == 4'h0))
    else $error("byte not spread over four blocks");

  // Block processing: syndromes, then correction and push
  proc_state_t ps_reg;
  logic pbank_reg, ph_reg;
  logic [1:0] blk_reg;
  logic [7:0] idx_reg, pk_reg, pn_reg, rd_byte;
  logic [7:0] s0_reg, s1_reg, apow_reg, tgt_reg, v_reg;
  logic [4:0] cnt_reg;
  logic push, fix_here;
  fifo_word_t push_word;

  rs_byte_ram #(.W(8), .AW(`RS_RAM_AW)) page_ram (
    .clk(clk),
    .we(wr_en),
    .wa(wr_addr),
    .wd(sh_next[7:0]),
    .ra({pbank_reg, blk_reg, idx_reg}),
    .rd(rd_byte)
  );

  assign fix_here = (s0_reg != 8'h00) && (v_reg == tgt_reg);
  assign push = (ps_reg == P_COR) && ph_reg && (cnt_reg != `RS_FIFO_FULL);
  assign push_word.first = (blk_reg == 2'h0) && (idx_reg == 8'h00);
  assign push_word.data = fix_here ? rd_byte ^ s0_reg : rd_byte;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ps_reg <= P_IDLE;
      {pbank_reg, ph_reg, blk_reg, idx_reg} <= 12'h000;
      {pk_reg, pn_reg, s0_reg, s1_reg} <= 32'h0000_0000;
      {apow_reg, tgt_reg, v_reg} <= 24'h00_0000;
      corr_pulse <= 1'b0;
    end else begin
      corr_pulse <= push && fix_here;
      case (ps_reg)
        P_IDLE: begin
          if (page_go) begin
            ps_reg <= P_SYN;
            pbank_reg <= bank_reg;
            pk_reg <= k_lat_reg;
            pn_reg <= n_lat_reg;
            {blk_reg, idx_reg, ph_reg} <= 11'h000;
            {s0_reg, s1_reg} <= 16'h0000;
            apow_reg <= 8'h01;
          end
        end
        P_SYN: begin
          ph_reg <= ~ph_reg;
          if (ph_reg) begin
            s0_reg <= s0_reg ^ rd_byte;
            s1_reg <= mulx(s1_reg) ^ rd_byte;
            if (idx_reg != 8'h00) apow_reg <= mulx(apow_reg);
            if (idx_reg == pk_reg - 8'h01) begin
              idx_reg <= 8'h00;
              ps_reg <= P_TGT;
            end else begin
              idx_reg <= idx_reg + 8'h01;
            end
          end
        end
        P_TGT: begin
          tgt_reg <= gf_mul(s0_reg, apow_reg);
          v_reg <= s1_reg;
          ps_reg <= P_COR;
        end
        P_COR: begin
          // A full FIFO holds this byte and stalls the block
          if (!ph_reg) begin
            ph_reg <= 1'b1;
          end else if (push) begin
            ph_reg <= 1'b0;
            v_reg <= mulx(v_reg);
            if (idx_reg == pn_reg - 8'h01) begin
              idx_reg <= 8'h00;
              {s0_reg, s1_reg} <= 16'h0000;
              apow_reg <= 8'h01;
              if (blk_reg == 2'(`RS_DEPTH - 3'h1)) begin
                ps_reg <= P_IDLE;
              end else begin
                blk_reg <= blk_reg + 2'h1;
                ps_reg <= P_SYN;
              end
            end else begin
              idx_reg <= idx_reg + 8'h01;
            end
          end
        end
        default: ps_reg <= P_IDLE;
      endcase
    end
  end

  order_a: assert property (push |-> (ps_reg == P_COR) &&
    (lk_reg != L_HUNT || pbank_reg != bank_reg))
    else $error("push outside correction pass");
  strip_a: assert property (push |-> idx_reg < pn_reg)
    else $error("check byte pushed");
  correct_a: assert property (push && fix_here |=> corr_pulse)
    else $error("correction not flagged");

  // Output FIFO, check bytes never enter it
  logic [`RS_FIFO_AW-1:0] wp_reg, rp_reg;
  logic pop, fetch_reg;
  fifo_word_t pop_word;
  rs_byte_ram #(.W(9), .AW(`RS_FIFO_AW)) out_fifo (
    .clk(clk),
    .we(push),
    .wa(wp_reg),
    .wd(push_word),
    .ra(rp_reg),
    .rd(pop_word)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {wp_reg, rp_reg} <= 8'h00;
      cnt_reg <= 5'h00;
    end else begin
      if (push) wp_reg <= wp_reg + 4'h1;
      if (pop) rp_reg <= rp_reg + 4'h1;
      cnt_reg <= cnt_reg + 5'(push) - 5'(pop);
    end
  end
  fifo_safe_a: assert property ((cnt_reg == `RS_FIFO_FULL) |-> !push)
    else $error("push into full FIFO");

  // Serialiser and descrambler
  logic [7:0] ser_reg;
  logic [3:0] bits_reg;
  logic [4:0] div_reg;
  logic first_reg;
  logic [14:0] dsr_reg, dsr_use;
  logic bit_start, din, dout;
  assign pop = (bits_reg == 4'h0) && !fetch_reg && (cnt_reg != 5'h00);
  assign bit_start = (bits_reg != 4'h0) && (div_reg == 5'h00);
  assign din = ser_reg[7];
  assign dsr_use = (first_reg && bits_reg == 4'h8) ? 15'h0000 : dsr_reg;
  assign dout = byp_s2 ? din : din ^ dsr_use[13] ^ dsr_use[14];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {ser_reg, bits_reg, div_reg, first_reg, fetch_reg} <= 19'h00000;
      dsr_reg <= 15'h0000;
      {out_data, out_clk, out_valid, locked} <= 4'h0;
    end else begin
      fetch_reg <= pop;
      locked <= (lk_reg != L_HUNT);
      if (fetch_reg) begin
        ser_reg <= pop_word.data;
        first_reg <= pop_word.first;
        bits_reg <= 4'h8;
        div_reg <= 5'h00;
      end else if (bits_reg != 4'h0) begin
        div_reg <= div_reg + 5'h01;
        if (bit_start) begin
          out_data <= dout;
          out_valid <= 1'b1;
          out_clk <= 1'b0;
          dsr_reg <= {dsr_use[13:0], din};
        end
        if (div_reg == 5'(`RS_OUT_HALF)) out_clk <= 1'b1;
        if (div_reg == 5'(`RS_OUT_DIV - 1)) begin
          div_reg <= 5'h00;
          bits_reg <= bits_reg - 4'h1;
          ser_reg <= {ser_reg[6:0], 1'b0};
        end
      end else begin
        out_valid <= 1'b0;
        out_clk <= 1'b0;
      end
    end
  end

  serial_a: assert property (fetch_reg |=> (bits_reg == 4'h8)
    ##1 (out_valid && !out_clk))
    else $error("byte not serialised");
  bypass_a: assert property (bit_start && byp_s2 && !fetch_reg
    |=> out_data == $past(din))
    else $error("bypass altered data");
  desc_align_a: assert property (bit_start && first_reg &&
    bits_reg == 4'h8 |=> out_data == $past(din) && dsr_reg[0] == $past(din))
    else $error("descrambler not aligned at page");
  desc_run_a: assert property (bit_start && !byp_s2 && !fetch_reg &&
    !(first_reg && bits_reg == 4'h8) |=>
    out_data == ($past(din) ^ $past(dsr_reg[13]) ^ $past(dsr_reg[14])))
    else $error("descrambler output wrong");

  lock_c: cover property (page_go);
  fix_c: cover property (push && fix_here);
  full_c: cover property (cnt_reg == `RS_FIFO_FULL);
  out_c: cover property (bit_start && first_reg);
endmodule // rs_outer_decoder_rx
`default_nettype wire

// *** design/rs_rx_defs.svh ***
/*
  Constants for the outer decoder receive path: unique word, code
  shapes per rate setting, memory sizes and serial output timing.
  Assumes inclusion by bare name from the package, not from the design files.
*/
`ifndef RS_RX_DEFS_SVH
`define RS_RX_DEFS_SVH

// Page marker that follows each page
`define RS_UW 16'h1ACF
// Blocks per page, equal to the transmit interleaver depth
`define RS_DEPTH 3'h4
// Block length k and data length n for each rate setting
`define RS_K0 8'h3C
`define RS_N0 8'h38
`define RS_K1 8'h7E
`define RS_N1 8'h70
`define RS_K2 8'hC2
`define RS_N2 8'hB2
`define RS_K3 8'hE1
`define RS_N3 8'hCD
// GF(256) reduction term of x^8+x^4+x^3+x^2+1
`define RS_GF_POLY 8'h1D
// Page store: bank, block, position
`define RS_RAM_AW 11
// Output FIFO depth as address width and full count
`define RS_FIFO_AW 4
`define RS_FIFO_FULL 5'h10
// Output bit time in ns and clock period in ns
`define RS_CLK_NS 4
`define RS_OUT_BIT_NS 48
`define RS_OUT_DIV (`RS_OUT_BIT_NS / `RS_CLK_NS)
`define RS_OUT_HALF (`RS_OUT_DIV / 2)

`endif

// *** design/rs_rx_pkg.sv ***
/*
  Types for the outer decoder receive path.
  Assumes rs_rx_defs.svh is on the include path.
*/
`default_nettype none
package rs_rx_pkg;
  `include "rs_rx_defs.svh"

  typedef enum logic [1:0] {
    L_HUNT = 2'b00,
    L_DATA = 2'b01,
    L_UW   = 2'b10
  } lock_state_t;

  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_SYN  = 2'b01,
    P_TGT  = 2'b10,
    P_COR  = 2'b11
  } proc_state_t;

  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } fifo_word_t;
endpackage
`default_nettype wire

// *** design/rs_byte_ram.sv ***
/*
  Simple dual-port memory with registered read data.
  Assumes one clock; contents are undefined until written.
*/
`default_nettype none
module rs_byte_ram #(
  parameter int W = 8,
  parameter int AW = 11
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] wa,
  input wire logic [W-1:0] wd,
  input wire logic [AW-1:0] ra,
  output logic [W-1:0] rd
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[wa] <= wd;
    end
    rd <= mem[ra];
  end
endmodule // rs_byte_ram
`default_nettype wire

// *** test/rs_link_tx_model.sv ***
/*
  Far-side link model: scrambles, block codes, interleaves and sends
  pages bit-serially with a link clock that stands still between words.
  Assumes the rate setting 0 code shape and the package constants.
*/
`default_nettype none
module rs_link_tx_model
  import rs_rx_pkg::*;
(
  output logic rx_clk_in,
  output logic rx_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] exp_q[$];
  logic [7:0] blk [4][256];
  logic [14:0] scr;
  int pg = 0;

  initial begin
    rx_clk_in = 1'b0;
    rx_data_in = 1'b0;
  end

  function automatic logic [7:0] gmul(logic [7:0] a, logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      r = {r[6:0], 1'b0} ^ (r[7] ? `RS_GF_POLY : 8'h00);
      if (b[i]) r = r ^ a;
    end
    return r;
  endfunction

  // Released data line shows the inverse of the last bit
  task automatic send_bit(input logic b);
    rx_data_in = b;
    #12 rx_clk_in = 1'b1;
    #24 rx_clk_in = 1'b0;
    #12 rx_data_in = ~b;
  endtask

  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) send_bit(w[i]);
  endtask

  task automatic send_page(input logic byp, input int err, input logic keep);
    logic [7:0] u, c, a, hb, p;
    int k, n;
    k = `RS_K0;
    n = `RS_N0;
    scr = 15'h0000;
    for (int b = 0; b < 4; b++) begin
      for (int i = 0; i < n; i++) begin
        u = 8'(pg * 7 + b * n + i);
        for (int j = 7; j >= 0; j--) begin
          c[j] = u[j] ^ scr[13] ^ scr[14];
          scr = {scr[13:0], c[j]};
        end
        blk[b][i] = c;
        if (keep) exp_q.push_back(byp ? c : u);
      end
      // Only the last two check bytes carry parity, the rest are zero
      for (int i = n; i < k; i++) blk[b][i] = 8'h00;
      a = 8'h00;
      hb = 8'h00;
      for (int i = 0; i < k; i++) begin
        a = a ^ blk[b][i];
        hb = gmul(hb, 8'h02) ^ blk[b][i];
      end
      p = 8'h00;
      for (int v = 0; v < 256; v++)
        if (gmul(8'(v), 8'h03) == (a ^ hb)) p = 8'(v);
      blk[b][k-2] = p;
      blk[b][k-1] = a ^ p;
    end
    if (err >= 0) blk[1][err] = blk[1][err] ^ 8'h5A;
    pg++;
    for (int i = 0; i < k; i++)
      for (int b = 0; b < 4; b++)
        for (int j = 7; j >= 0; j--) send_bit(blk[b][i][j]);
  endtask
endmodule // rs_link_tx_model
`default_nettype wire

// *** test/tb_rs_outer_decoder_receive_path.sv ***
/*
  Self-checking bench for the receive outer decoder path.
  Assumes the link model supplies pages and the expected byte queue.
*/
`default_nettype none
module tb_rs_outer_decoder_receive_path;
  import rs_rx_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic byp; int err; int corr;} row_t;
  // Data error is corrected; check byte error passes unflagged
  row_t rows [2] = '{'{1'b0, 5, 1}, '{1'b1, 58, 0}};
  logic clk, rst, rx_clk_in, rx_data_in, bypass_in;
  logic [1:0] rate_sel;
  logic out_data, out_clk, out_valid, locked, corr_pulse, oclk_d;
  logic [7:0] sh;
  int error_cnt = 0, n_checks = 0, nb = 0, byte_cnt = 0, corr_cnt = 0;
  int cyc = 0, total = 0, corr_exp = 0;

  rs_outer_decoder_rx rs_outer_decoder_rx_i (
    .clk(clk), .rst(rst), .rx_clk_in(rx_clk_in), .rx_data_in(rx_data_in),
    .rate_sel(rate_sel), .bypass_in(bypass_in), .out_data(out_data),
    .out_clk(out_clk), .out_valid(out_valid), .locked(locked),
    .corr_pulse(corr_pulse)
  );
  rs_link_tx_model rs_link_tx_model_i (
    .rx_clk_in(rx_clk_in), .rx_data_in(rx_data_in)
  );

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task wait_bytes(input int n);
    for (int i = 0; i < 60000 && byte_cnt < n; i++) @(negedge clk);
    check(16'(byte_cnt), 16'(n));
  endtask

  always #2 clk = ~clk;

  // Three rate 0 pages take about 73000 cycles; hang limit above that
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      finish_test;
    end
  end

  // Bits are taken on the rising output clock, MSB first
  // Sampled mid-cycle, clear of the edge that launches the outputs
  always @(negedge clk) begin
    oclk_d <= out_clk;
    if (corr_pulse === 1'b1) corr_cnt++;
    if (out_clk === 1'b1 && oclk_d === 1'b0 && out_valid === 1'b1) begin
      sh = {sh[6:0], out_data};
      nb++;
      if (nb == 8) begin
        nb = 0;
        byte_cnt++;
        if (rs_link_tx_model_i.exp_q.size() == 0) check(sh, ~sh);
        else check(sh, rs_link_tx_model_i.exp_q.pop_front());
      end
    end
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    rate_sel = 2'h0;
    bypass_in = 1'b0;
    oclk_d = 1'b0;
    sh = 8'h00;
    repeat (20) @(posedge clk);
    @(negedge clk);
    check({3'h0, out_data, out_clk, out_valid, locked, corr_pulse}, 8'h00);
    @(posedge clk) rst <= 1'b0;
    repeat (4) @(posedge clk);
    rs_link_tx_model_i.send_word(16'h1ACE);
    repeat (8) @(negedge clk);
    check({7'h00, locked}, 8'h00);
    rs_link_tx_model_i.send_word(`RS_UW);
    repeat (8) @(negedge clk);
    check({7'h00, locked}, 8'h01);
    foreach (rows[r]) begin
      // Bypass changes only once the previous page has drained
      fork
        rs_link_tx_model_i.send_page(rows[r].byp, rows[r].err, 1'b1);
        begin
          wait_bytes(total);
          check(8'(corr_cnt), 8'(corr_exp));
          @(posedge clk) bypass_in <= rows[r].byp;
        end
      join
      rs_link_tx_model_i.send_word(`RS_UW);
      total += 4 * `RS_N0;
      corr_exp += rows[r].corr;
    end
    // Rate change in mid page must not move the page end
    @(posedge clk) rate_sel <= 2'h1;
    fork
      rs_link_tx_model_i.send_page(1'b0, -1, 1'b0);
      begin
        wait_bytes(total);
        check(8'(corr_cnt), 8'(corr_exp));
      end
    join
    // Page followed by a wrong marker is discarded and lock is lost
    rs_link_tx_model_i.send_word(16'h1ACE);
    repeat (20) @(negedge clk);
    check({7'h00, locked}, 8'h00);
    repeat (3000) @(negedge clk);
    check(16'(byte_cnt), 16'(total));
    check(8'(rs_link_tx_model_i.exp_q.size()), 8'h00);
    finish_test;
  end
endmodule // tb_rs_outer_decoder_receive_path
`default_nettype wire
